/* include/lcdctl_pkg.sv */
// register map, field positions, reset values and timing counts of the lcd control block
package lcdctl_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_CONTROL = 16'hffa1;
  localparam logic [15:0] IDX_CONTROL_SECOND = 16'hffa2;
  localparam logic [15:0] IDX_STATUS = 16'hffa8;
  localparam logic [15:0] IDX_RAM_FIRST = 16'hf370;
  localparam logic [15:0] IDX_RAM_LAST = 16'hf37f;
  localparam int ADDR_W = 18;
  localparam int RAM_WORDS = 16;
  localparam int SEG_N = 16;
  localparam int COM_N = 4;
  // lcd_control fields
  localparam int CTL_SUPPLY_BIT = 6;
  localparam int CTL_ACTIVATE_BIT = 5;
  localparam int CTL_SOURCE_BIT = 4;
  localparam int CTL_FRAME_MSB = 3;
  // lcd_control_second fields
  localparam int C2_WAVE_BIT = 7;
  localparam int C2_BOOST_DIV_BIT = 6;
  localparam int C2_SPLIT_BIT = 5;
  localparam int C2_REGULATOR_BIT = 4;
  // status fields
  localparam int ST_SUPPLY_BIT = 0;
  localparam int ST_REGULATOR_BIT = 1;
  localparam int ST_POLARITY_BIT = 2;
  localparam int ST_COM_LSB = 3;
  localparam int ST_RUNNING_BIT = 7;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] CONTROL_SECOND_RST = 8'h00;
  // subclock rate derived from the system clock
  localparam int CLK_HZ = 100_000_000;
  localparam int SUBCLK_HZ = 32_768;
  localparam int SUBCLK_DIV = CLK_HZ / SUBCLK_HZ;
  localparam int SUB_W = 12;
  // operating clocks per frame: 32.768 kHz / 2 over 64 Hz
  localparam int FRAME_HZ = 64;
  localparam int FRAME_OP_CLKS = SUBCLK_HZ / 2 / FRAME_HZ;
  localparam int FRM_W = 8;
  localparam int PRE_W = 7;
endpackage

/* src/lcdctl_top.sv */
// segment lcd controller: control registers, apb slave, frame timing and drivers
//
// The APB register port was decided locally.
`timescale 1ns/1ps
// Behaviour
// - Bit 6 of lcd_control switches the lcd drive supply on when 1 and off when 0.
// - The drive supply is forced off while the controller is not activated or the chip is in standby.
// - Bit 5 runs the controller when 1 and, when 0, halts all its operation except the regulator and split-resistor enables, keeping every register.
// - Bit 4 shows display memory when 1 and blank patterns regardless of memory when 0.
// - Bits 3 to 0 choose the operating clock, pattern 0,x,0,1 giving subclock/2 and a 64 Hz frame.
// - Bit 7 of lcd_control_second selects drive waveform A when 0 and waveform B when 1.
// - Bit 6 of lcd_control_second makes the step-up clock the operating clock over 4 or over 8.
// - Bit 5 of lcd_control_second connects the split-resistor network when 1.
// - Bit 4 of lcd_control_second enables the constant-voltage supply circuit when 1.
// - Sixteen bytes of display memory are read and written and shown without further command.
module lcdctl_top #(
  parameter int SEG_N = lcdctl_pkg::SEG_N,
  parameter int COM_N = lcdctl_pkg::COM_N
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [lcdctl_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_standby,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [SEG_N-1:0] o_seg,
  output logic [COM_N-1:0] o_com,
  output logic o_drive_supply_on,
  output logic o_regulator_on,
  output logic o_split_connect,
  output logic o_boost_clk
);
  logic [7:0] ctl_q;
  logic [7:0] ctl2_q;
  logic [7:0] ram_q [lcdctl_pkg::RAM_WORDS];
  logic [lcdctl_pkg::SUB_W-1:0] sub_q;
  logic [lcdctl_pkg::PRE_W-1:0] pre_q;
  logic [lcdctl_pkg::FRM_W-1:0] frm_q;
  logic [2:0] bcnt_q;
  logic frame_tog_q;
  logic phiw_en;
  logic op_en;
  logic [2:0] div_exp;
  logic [lcdctl_pkg::PRE_W-1:0] div_mask;
  logic active;
  logic show_ram;
  logic wave_b;
  logic pol_w;
  logic [1:0] com_idx;
  logic [15:0] idx;
  logic aligned;
  logic hit_ctl;
  logic hit_ctl2;
  logic hit_st;
  logic hit_ram;
  logic [3:0] ram_idx;
  logic setup;
  logic access;
  logic wr_ctl;
  logic wr_ctl2;
  logic wr_ram;
  logic [7:0] status_w;
  logic [31:0] rdata_w;

  // address decode; unaligned addresses count as unmapped
  assign idx = i_paddr[lcdctl_pkg::ADDR_W-1:2];
  assign aligned = (i_paddr[1:0] == 2'h0);
  assign hit_ctl = aligned && (idx == lcdctl_pkg::IDX_CONTROL);
  assign hit_ctl2 = aligned && (idx == lcdctl_pkg::IDX_CONTROL_SECOND);
  assign hit_st = aligned && (idx == lcdctl_pkg::IDX_STATUS);
  assign hit_ram = aligned && (idx >= lcdctl_pkg::IDX_RAM_FIRST) &&
                   (idx <= lcdctl_pkg::IDX_RAM_LAST);
  assign ram_idx = idx[3:0];
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable && o_pready;
  assign wr_ctl = access && i_pwrite && hit_ctl;
  assign wr_ctl2 = access && i_pwrite && hit_ctl2;
  assign wr_ram = access && i_pwrite && hit_ram;

  // decoded control fields
  assign active = ctl_q[lcdctl_pkg::CTL_ACTIVATE_BIT];
  assign show_ram = ctl_q[lcdctl_pkg::CTL_SOURCE_BIT];
  assign wave_b = ctl2_q[lcdctl_pkg::C2_WAVE_BIT];
  assign com_idx = frm_q[lcdctl_pkg::FRM_W-1 -: 2];

  // status word reflects live controller state
  always_comb begin
    status_w = 8'h00;
    status_w[lcdctl_pkg::ST_SUPPLY_BIT] = o_drive_supply_on;
    status_w[lcdctl_pkg::ST_REGULATOR_BIT] = o_regulator_on;
    status_w[lcdctl_pkg::ST_POLARITY_BIT] = pol_w;
    status_w[lcdctl_pkg::ST_COM_LSB +: 2] = com_idx;
    status_w[lcdctl_pkg::ST_RUNNING_BIT] = active;
  end

  // read mux, narrow registers sit in the low byte
  always_comb begin
    rdata_w = 32'h0000_0000;
    if (hit_ctl) begin
      rdata_w[7:0] = ctl_q;
    end else if (hit_ctl2) begin
      rdata_w[7:0] = ctl2_q;
    end else if (hit_st) begin
      rdata_w[7:0] = status_w;
    end else if (hit_ram) begin
      rdata_w[7:0] = ram_q[ram_idx];
    end
  end

  // apb answer is prepared in the setup cycle, so every access ends after one access cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (setup) begin
      o_pready <= 1'b1;
      o_pslverr <= !(hit_ctl || hit_ctl2 || hit_st || hit_ram);
      o_prdata <= i_pwrite ? 32'h0000_0000 : rdata_w;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // control registers keep their contents while the controller is halted
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_q <= lcdctl_pkg::CONTROL_RST;
      ctl2_q <= lcdctl_pkg::CONTROL_SECOND_RST;
    end else begin
      if (wr_ctl) begin
        ctl_q <= i_pwdata[7:0];
      end
      if (wr_ctl2) begin
        ctl2_q <= i_pwdata[7:0];
      end
    end
  end

  // display memory, no reset so it behaves like ram
  always_ff @(posedge i_clk_sys) begin
    if (wr_ram) begin
      ram_q[ram_idx] <= i_pwdata[7:0];
    end
  end

  // subclock enable; free running so a restart lines up with the subclock grid
  assign phiw_en = (sub_q == lcdctl_pkg::SUB_W'(lcdctl_pkg::SUBCLK_DIV - 1));
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sub_q <= '0;
    end else if (phiw_en) begin
      sub_q <= '0;
    end else begin
      sub_q <= sub_q + 1'b1;
    end
  end

  // operating clock: subclock over 2^exp, exp from the frame-select bits
  always_comb begin
    div_exp = {ctl_q[lcdctl_pkg::CTL_FRAME_MSB], ctl_q[1:0]};
    if (div_exp > 3'd7) begin
      div_exp = 3'd7;
    end
    div_mask = lcdctl_pkg::PRE_W'((8'h01 << div_exp) - 8'h01);
  end
  assign op_en = active && phiw_en && ((pre_q & div_mask) == div_mask);

  // prescaler, frame counter and boost counter all freeze while halted
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= '0;
    end else if (active && phiw_en) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frm_q <= '0;
      frame_tog_q <= 1'b0;
    end else if (op_en) begin
      frm_q <= frm_q + 1'b1;
      if (frm_q == lcdctl_pkg::FRM_W'(lcdctl_pkg::FRAME_OP_CLKS - 1)) begin
        frame_tog_q <= !frame_tog_q;
      end
    end
  end

  // waveform a inverts inside each common slot, waveform b once per frame
  assign pol_w = wave_b ? frame_tog_q : frm_q[lcdctl_pkg::FRM_W-3];

  // step-up clock from the operating clock over 4 or 8, stopped with the regulator
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bcnt_q <= 3'h0;
      o_boost_clk <= 1'b0;
    end else if (op_en) begin
      bcnt_q <= bcnt_q + 3'h1;
      o_boost_clk <= ctl2_q[lcdctl_pkg::C2_REGULATOR_BIT] &&
                     (ctl2_q[lcdctl_pkg::C2_BOOST_DIV_BIT] ? (bcnt_q + 3'h1) >= 3'h4 :
                      (bcnt_q[1:0] + 2'h1) >= 2'h2);
    end else if (!active || !ctl2_q[lcdctl_pkg::C2_REGULATOR_BIT]) begin
      o_boost_clk <= 1'b0;
    end
  end

  // supply gates; halt and standby override the gate bit
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_drive_supply_on <= 1'b0;
      o_regulator_on <= 1'b0;
      o_split_connect <= 1'b0;
    end else begin
      o_drive_supply_on <= ctl_q[lcdctl_pkg::CTL_SUPPLY_BIT] && active && !i_standby;
      o_regulator_on <= ctl2_q[lcdctl_pkg::C2_REGULATOR_BIT];
      o_split_connect <= ctl2_q[lcdctl_pkg::C2_SPLIT_BIT];
    end
  end

  // electrode levels: selected common and lit segments differ from polarity
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_seg <= '0;
      o_com <= '0;
    end else if (!active) begin
      o_seg <= '0;
      o_com <= '0;
    end else begin
      for (int s = 0; s < SEG_N; s++) begin
        o_seg[s] <= (show_ram && ram_q[s][com_idx]) ^ pol_w;
      end
      for (int c = 0; c < COM_N; c++) begin
        o_com[c] <= (com_idx == c[1:0]) ^ pol_w;
      end
    end
  end

  // helpers for the checks below
  logic [13:0] gap_q;
  logic cfg_chg_q;
  logic [3:0] wk_q;
  logic [7:0] wb_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_q <= '0;
      cfg_chg_q <= 1'b1;
      wk_q <= 4'h0;
      wb_q <= 8'h00;
    end else begin
      gap_q <= op_en ? 14'h0001 : gap_q + 14'h0001;
      cfg_chg_q <= wr_ctl ? 1'b1 : (op_en ? 1'b0 : cfg_chg_q);
      if (wr_ram) begin
        wk_q <= ram_idx;
        wb_q <= i_pwdata[7:0];
      end
    end
  end

  sequence s_halted;
    !active;
  endsequence

  sequence s_ram_write_shown;
    wr_ram && active && show_ram ##1 !wr_ram;
  endsequence

  a_supply_halt_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_halted |=> !o_drive_supply_on) else $error("drive supply on while halted");
  a_supply_standby_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_standby |=> !o_drive_supply_on) else $error("drive supply on in standby");
  a_supply_gate_on: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ctl_q[lcdctl_pkg::CTL_SUPPLY_BIT] && active && !i_standby |=> o_drive_supply_on)
    else $error("drive supply not on");
  a_halt_freezes_all: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_halted ##1 s_halted |-> $stable(frm_q) && $stable(pre_q) && o_seg == '0 && o_com == '0)
    else $error("controller moved while halted");
  a_blank_pattern: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    active && !show_ram |=> o_seg == {SEG_N{$past(pol_w)}}) else $error("blank not shown");
  a_frame_div_two: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    op_en && !cfg_chg_q && ctl_q[3] == 1'b0 && ctl_q[1:0] == 2'b01 |->
    gap_q == 14'(2 * lcdctl_pkg::SUBCLK_DIV)) else $error("operating clock not subclock/2");
  a_wave_a_flip: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    op_en && !wave_b && !wr_ctl2 && frm_q[5:0] == 6'h1f |=> pol_w != $past(pol_w))
    else $error("waveform a polarity did not flip");
  a_wave_b_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wave_b && !wr_ctl2 && !(op_en && frm_q == 8'hff) |=> $stable(pol_w))
    else $error("waveform b polarity changed mid frame");
  a_boost_div_four: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    op_en && !wr_ctl2 && !ctl2_q[lcdctl_pkg::C2_BOOST_DIV_BIT] &&
    ctl2_q[lcdctl_pkg::C2_REGULATOR_BIT] && bcnt_q[1:0] == 2'b01 ##1 1'b1 ##0 !op_en
    |-> o_boost_clk != $past(o_boost_clk)) else $error("step-up clock not over four");
  a_split_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_ctl2 |=> ##1 o_split_connect == $past(i_pwdata[lcdctl_pkg::C2_SPLIT_BIT], 2))
    else $error("split resistor not following");
  a_regulator_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_ctl2 |=> ##1 o_regulator_on == $past(i_pwdata[lcdctl_pkg::C2_REGULATOR_BIT], 2))
    else $error("regulator enable not following");
  a_ram_shown: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_ram_write_shown |-> ##1 o_seg[$past(wk_q)] == (wb_q[$past(com_idx)] ^ $past(pol_w)))
    else $error("written display data not shown");

  // bus answer: ready stands one cycle, so a held access never commits twice
  a_ready_one_cycle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_pready |=> !o_pready) else $error("ready held for more than one cycle");
  a_unmapped_error: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    setup && !(hit_ctl || hit_ctl2 || hit_st || hit_ram) |=> o_pready && o_pslverr)
    else $error("unmapped access answered without error");
  a_mapped_no_error: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    setup && (hit_ctl || hit_ctl2 || hit_st || hit_ram) |=> o_pready && !o_pslverr)
    else $error("mapped access answered with error");
  a_read_low_byte: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_pready |-> o_prdata[31:8] == 24'h000000)
    else $error("read data above the low byte not zero");

  // halting keeps every register and silences the step-up clock
  a_ctl_kept: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !wr_ctl && !wr_ctl2 |=> $stable(ctl_q) && $stable(ctl2_q))
    else $error("control register changed without a write");
  a_halt_boost_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_halted |=> !o_boost_clk) else $error("step-up clock running while halted");

  // status read shows the live running state
  a_status_running: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    setup && !i_pwrite && hit_st |=> o_prdata[lcdctl_pkg::ST_RUNNING_BIT] == $past(active))
    else $error("status running bit wrong");

  // step-up clock: over eight it rises on the fourth count, and the regulator bit gates it
  a_boost_div_eight: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    op_en && ctl2_q[lcdctl_pkg::C2_BOOST_DIV_BIT] && ctl2_q[lcdctl_pkg::C2_REGULATOR_BIT] &&
    bcnt_q == 3'h3 |=> o_boost_clk) else $error("step-up clock not over eight");
  a_regulator_off_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !ctl2_q[lcdctl_pkg::C2_REGULATOR_BIT] |=> !o_boost_clk)
    else $error("step-up clock running with regulator off");

  // commons: exactly one differs from the polarity level in every slot
  a_one_common_selected: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    active |=> $countones(o_com ^ {COM_N{$past(pol_w)}}) == 1)
    else $error("common selection not one-hot");

  // a memory write lands in the addressed byte at once
  a_ram_write_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_ram |=> ram_q[$past(ram_idx)] == $past(i_pwdata[7:0]))
    else $error("display memory write lost");
endmodule

/* sim/lcdctl_panel_model.sv */
// behavioural lcd panel: shows which segments are lit from the electrode levels
`timescale 1ns/1ps
module lcdctl_panel_model #(
  parameter int SEG_N = 16,
  parameter int COM_N = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [SEG_N-1:0] i_seg,
  input wire logic [COM_N-1:0] i_com,
  input wire logic i_supply_on,
  output logic [SEG_N-1:0] o_lit
);
  logic sel;
  // the selected common is the odd one out, whichever polarity is in force
  assign sel = ($countones(i_com) == 1);
  // a segment lights only with drive supply present and its level matching the selected common
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lit <= '0;
    end else begin
      o_lit <= i_supply_on ? ~(i_seg ^ {SEG_N{sel}}) : '0;
    end
  end
endmodule

/* sim/lcdctl_top_tb_top.sv */
// self-checking bench for the lcd control block over apb
`timescale 1ns/1ps
module lcdctl_top_tb_top;
  localparam logic [17:0] A_CTL = {lcdctl_pkg::IDX_CONTROL, 2'b00};
  localparam logic [17:0] A_CTL2 = {lcdctl_pkg::IDX_CONTROL_SECOND, 2'b00};
  localparam logic [17:0] A_ST = {lcdctl_pkg::IDX_STATUS, 2'b00};
  localparam logic [17:0] A_RAM = {lcdctl_pkg::IDX_RAM_FIRST, 2'b00};
  localparam int OP = lcdctl_pkg::SUBCLK_DIV * 2;
  logic i_clk_sys, i_rst_n, i_psel, i_penable, i_pwrite, i_standby, err;
  logic o_pready, o_pslverr, o_drive_supply_on, o_regulator_on, o_split_connect, o_boost_clk;
  logic [17:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [15:0] o_seg, lit;
  logic [3:0] o_com;
  int n_fail, compares, k;

  lcdctl_top dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_standby(i_standby), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_seg(o_seg), .o_com(o_com), .o_drive_supply_on(o_drive_supply_on),
    .o_regulator_on(o_regulator_on), .o_split_connect(o_split_connect),
    .o_boost_clk(o_boost_clk));
  lcdctl_panel_model panel (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_seg(o_seg),
    .i_com(o_com), .i_supply_on(o_drive_supply_on), .o_lit(lit));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; the request is held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (o_pready !== 1'b1) n_fail++;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // registered outputs follow a write two edges later
  task automatic settle();
    repeat (3) @(posedge i_clk_sys);
  endtask

  // wait, bounded, until the step-up clock shows level v
  task automatic blevel(input logic v, output int c);
    c = 0;
    while (o_boost_clk !== v && c < 60000) begin
      @(posedge i_clk_sys);
      c++;
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog: the step-up clock tests end near 73200 cycles, so this leaves margin
  initial begin
    repeat (90000) @(posedge i_clk_sys);
    n_fail++;
    complete_run();
  end

  initial begin
    {i_rst_n, i_psel, i_penable, i_pwrite, i_standby} = 5'h00;
    i_paddr = 18'h00000;
    i_pwdata = 32'h00000000;
    repeat (5) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    apb(1'b0, A_CTL, 32'h0);
    check("control reset", rd, 32'h0);
    apb(1'b0, A_CTL2, 32'h0);
    check("control2 reset", rd, 32'h0);
    apb(1'b0, 18'h3ff00, 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    $display("test registers done");
    apb(1'b1, A_CTL2, 32'h30);
    apb(1'b0, A_CTL2, 32'h0);
    check("control2 back", rd, 32'h30);
    settle();
    check("split", 32'(o_split_connect), 32'h1);
    check("regulator", 32'(o_regulator_on), 32'h1);
    apb(1'b1, A_CTL2, 32'h00);
    settle();
    check("split off", 32'(o_split_connect), 32'h0);
    check("regulator off", 32'(o_regulator_on), 32'h0);
    apb(1'b1, A_CTL2, 32'hb0);
    apb(1'b0, A_CTL2, 32'h0);
    check("waveform b", rd, 32'hb0);
    apb(1'b1, A_CTL2, 32'hb0);
    $display("test supply circuit done");
    for (k = 0; k < 16; k++) apb(1'b1, A_RAM + 18'(4 * k), (k == 0) ? 32'h0f : 32'h00);
    apb(1'b0, A_RAM, 32'h0);
    check("memory back", rd, 32'h0f);
    apb(1'b1, A_CTL, 32'h71);
    settle();
    check("supply on", 32'(o_drive_supply_on), 32'h1);
    check("lit seg0", 32'(lit[0]), 32'h1);
    check("dark seg1", 32'(lit[1]), 32'h0);
    apb(1'b0, A_ST, 32'h0);
    check("status supply", rd & 32'h1, 32'h1);
    apb(1'b1, A_RAM + 18'h4, 32'h0f);
    settle();
    check("lit seg1", 32'(lit[1]), 32'h1);
    apb(1'b1, A_CTL, 32'h61);
    settle();
    check("blank", 32'(lit), 32'h0);
    apb(1'b1, A_CTL, 32'h31);
    settle();
    check("gate off", 32'(o_drive_supply_on), 32'h0);
    apb(1'b1, A_CTL, 32'h71);
    i_standby <= 1'b1;
    settle();
    check("standby off", 32'(o_drive_supply_on), 32'h0);
    i_standby <= 1'b0;
    settle();
    check("standby left", 32'(o_drive_supply_on), 32'h1);
    apb(1'b1, A_CTL, 32'h51);
    settle();
    check("halt supply", 32'(o_drive_supply_on), 32'h0);
    check("halt drive", {12'h0, o_com, o_seg}, 32'h0);
    apb(1'b0, A_CTL, 32'h0);
    check("halt keeps", rd, 32'h51);
    apb(1'b0, A_CTL2, 32'h0);
    check("halt keeps 2", rd, 32'hb0);
    $display("test display done");
    apb(1'b1, A_CTL, 32'h71);
    blevel(1'b0, k);
    blevel(1'b1, k);
    blevel(1'b0, k);
    check("boost div4 high", 32'(k), 32'(2 * OP));
    // the first high phase after the switch is partial, so time the full low phase after it
    apb(1'b1, A_CTL2, 32'h70);
    blevel(1'b1, k);
    blevel(1'b0, k);
    blevel(1'b1, k);
    check("boost div8 low", 32'(k), 32'(4 * OP));
    $display("test step-up clock done");
    complete_run();
  end
endmodule
